// ---- cmd_link_defines.svh ----
`ifndef CMD_LINK_DEFINES_SVH
`define CMD_LINK_DEFINES_SVH

// Framing bytes
`define FRAME_HEADER 8'hFF
`define FRAME_ESCAPE 8'hFE
`define ESC_OFFSET 8'h80
`define REPLY_ACK 8'h06
`define REPLY_NAK 8'h15
`define SIZE_SHORT 8'h02
`define SIZE_LONG 8'h03

// Register map: mirrors, volatile copies, read-only
`define NV_BASE 8'h00
`define NV_LAST 8'h0D
`define VOL_BASE 8'h4B
`define VOL_LAST 8'h58
`define RO_BASE 8'h22
`define RO_LAST 8'h27
`define REG_COUNT 14

// Timing at 10 MHz (100 ns period)
`define CLK_PERIOD_NS 100
`define SELECT_HOLD_US 20
`define SELECT_HOLD_CYC ((`SELECT_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NV_WRITE_MS 16
`define NV_WRITE_CYC ((`NV_WRITE_MS * 1000000) / `CLK_PERIOD_NS)

// Buffer
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8

`endif

// ---- cmd_link_pkg.sv ----
package cmd_link_pkg;
    typedef enum logic [7:0] {
        P_IDLE = 8'b0000_0001,
        P_SIZE = 8'b0000_0010,
        P_BODY = 8'b0000_0100,
        P_EXEC = 8'b0000_1000,
        P_NVWAIT = 8'b0001_0000,
        P_REPLY = 8'b0010_0000,
        P_DROP = 8'b0100_0000,
        P_LOAD = 8'b1000_0000
    } parse_state_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_SEND = 4'b0010,
        H_HOLD = 4'b0100,
        H_WAIT = 4'b1000
    } host_state_t;
endpackage

// ---- cmd_link_if.sv ----
`timescale 1ns/10ps
interface cmd_link_if;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic command_select_n;

    modport device (
        input rx_data,
        input rx_valid,
        output rx_ready,
        output tx_data,
        output tx_valid,
        input command_select_n
    );
    modport host (
        output rx_data,
        output rx_valid,
        input rx_ready,
        input tx_data,
        input tx_valid,
        output command_select_n
    );
endinterface

// ---- byte_fifo.sv ----
`timescale 1ns/10ps
// Small synchronous FIFO; full and empty from an occupancy count
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer wrap assumes a power-of-two depth
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // byte_fifo

// ---- cmd_device.sv ----
`timescale 1ns/10ps
`include "cmd_link_defines.svh"
// Notes on behaviour
// R1: Select high routes bytes to payload.
// R2: Select low routes bytes to parser.
// R3: Host holds select low plus 20 us.
// R4: Long select low is harmless.
// R5: Radio packets still reach UART during commands.
// R6: Mirrors load volatile copies at power-up.
// R7: Escape 0xFE plus value minus 128.
// R8: Frames start 0xFF then size byte.
// R9: Short write: FF 02 reg value.
// R10: Long write: FF 03 reg FE low7.
// R11: Volatile write instant; mirror write stalls.
// R12: Accepted write answers ACK 0x06.
// R13: Host resends write lacking ACK. cmd_host does not resend; retry is left to its user.
// R14: Bad write target answers NAK, no change.
// R15: Read: FF 02 FE reg.
// R16: Read answer ACK, register, raw value.
// R17: Bad read register answers NAK only.
// R18: Errors or completion return to idle hunting.
module cmd_device #(
    parameter int NV_WRITE_CYCLES = `NV_WRITE_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    cmd_link_if.device link,
    output logic [7:0] payload_data,
    output logic payload_valid,
    input wire logic payload_ready,
    input wire logic [7:0] radio_data,
    input wire logic radio_valid,
    output logic radio_ready,
    output logic [`REG_COUNT*8-1:0] config_regs
);
    // ****
    // Types and helpers
    // ****
    typedef struct packed {
        cmd_link_pkg::parse_state_t st;
        logic [7:0] size;
        logic [1:0] idx;
        logic esc;
        logic [1:0] nfields;
        logic rd;
        logic [7:0] field0;
        logic [7:0] field1;
        logic [`REG_COUNT*8-1:0] vol;
        logic [`REG_COUNT*8-1:0] nv;
        logic [23:0] wait_cnt;
        logic [23:0] reply;
        logic [1:0] reply_len;
        logic [3:0] load_idx;
        logic [7:0] tx_data;
        logic tx_valid;
        logic rx_ready;
        logic [7:0] pay_data;
        logic pay_valid;
        logic radio_ready;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;

    // Register kinds: 1 volatile, 2 mirror, 3 read-only, 0 none
    function automatic logic [1:0] reg_kind(input logic [7:0] r);
        if (r >= `VOL_BASE && r <= `VOL_LAST) return 2'd1;
        if (r <= `NV_LAST) return 2'd2;
        if (r >= `RO_BASE && r <= `RO_LAST) return 2'd3;
        return 2'd0;
    endfunction

    function automatic logic [3:0] reg_slot(input logic [7:0] r);
        if (r >= `VOL_BASE) return 4'(r - `VOL_BASE);
        return 4'(r);
    endfunction

    // Payload path buffered so a busy radio stalls the UART
    logic fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic fifo_out_valid;

    byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) pay_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_data(link.rx_data),
        .in_valid(link.rx_valid && s_q.rx_ready && link.command_select_n), // see R1
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(!s_q.pay_valid || payload_ready)
    );

    assign link.tx_data = s_q.tx_data;
    assign link.tx_valid = s_q.tx_valid;
    assign link.rx_ready = s_q.rx_ready;
    assign payload_data = s_q.pay_data;
    assign payload_valid = s_q.pay_valid;
    assign radio_ready = s_q.radio_ready;
    assign config_regs = s_q.vol; // see R6

    // ****
    // Next state
    // ****
    always_comb begin
        logic [7:0] b;
        logic cmd_take;
        logic [3:0] slot;
        b = '0;
        cmd_take = 1'b0;
        slot = '0;
        s_d = s_q;
        s_d.tx_valid = 1'b0;
        // Registered ready drops a cycle after each take, as room may be gone by then
        s_d.rx_ready = !(link.rx_valid && s_q.rx_ready) && (link.command_select_n
            ? fifo_in_ready : s_q.st inside {cmd_link_pkg::P_IDLE, cmd_link_pkg::P_SIZE,
            cmd_link_pkg::P_BODY, cmd_link_pkg::P_DROP}); // see R4
        cmd_take = link.rx_valid && s_q.rx_ready && !link.command_select_n; // see R2
        b = link.rx_data;
        // Payload register drains FIFO
        if (!s_q.pay_valid || payload_ready) begin
            s_d.pay_valid = fifo_out_valid;
            s_d.pay_data = fifo_out_data;
        end
        // Radio bytes have their own UART slot when no reply is going out
        if (radio_valid && s_q.radio_ready) begin
            s_d.tx_data = radio_data; // see R5
            s_d.tx_valid = 1'b1;
        end
        case (s_q.st)
            cmd_link_pkg::P_LOAD: begin
                // Copy mirrors one by one after reset
                s_d.vol[s_q.load_idx*8 +: 8] = s_q.nv[s_q.load_idx*8 +: 8]; // see R6
                s_d.load_idx = s_q.load_idx + 4'd1;
                if (s_q.load_idx == 4'(`REG_COUNT - 1)) s_d.st = cmd_link_pkg::P_IDLE;
            end
            cmd_link_pkg::P_IDLE, cmd_link_pkg::P_DROP: begin
                if (cmd_take && b == `FRAME_HEADER) begin // see R8
                    s_d.st = cmd_link_pkg::P_SIZE;
                end
            end
            cmd_link_pkg::P_SIZE: begin
                if (cmd_take) begin
                    s_d.size = b;
                    s_d.idx = '0;
                    s_d.esc = 1'b0;
                    s_d.nfields = '0;
                    s_d.rd = 1'b0;
                    if (b == `SIZE_SHORT || b == `SIZE_LONG) s_d.st = cmd_link_pkg::P_BODY;
                    else s_d.st = cmd_link_pkg::P_DROP; // see R18
                end
            end
            cmd_link_pkg::P_BODY: begin
                if (cmd_take) begin
                    s_d.idx = s_q.idx + 2'd1;
                    if (b == `FRAME_ESCAPE && !s_q.esc) begin
                        s_d.esc = 1'b1;
                        if (s_q.nfields == 2'd0) s_d.rd = 1'b1; // see R15
                    end else begin
                        s_d.esc = 1'b0;
                        // Rebuild escaped value; read escape is a marker only
                        if (s_q.esc && !(s_q.rd && s_q.nfields == 2'd0)) begin
                            b = b | `ESC_OFFSET; // see R7
                        end
                        if (s_q.nfields == 2'd0) s_d.field0 = b;
                        else s_d.field1 = b;
                        s_d.nfields = s_q.nfields + 2'd1;
                    end
                    if ({6'd0, s_q.idx} + 8'd1 == s_q.size) begin
                        s_d.st = cmd_link_pkg::P_EXEC;
                    end else if (s_q.idx == 2'd3) begin
                        s_d.st = cmd_link_pkg::P_DROP;
                    end
                end
            end
            cmd_link_pkg::P_EXEC: begin
                slot = reg_slot(s_q.field0);
                s_d.reply = {`REPLY_NAK, 16'h0000};
                s_d.reply_len = 2'd1;
                s_d.st = cmd_link_pkg::P_REPLY;
                if (s_q.rd && s_q.nfields == 2'd1 && s_q.size == `SIZE_SHORT) begin
                    if (reg_kind(s_q.field0) == 2'd1) begin // see R16
                        s_d.reply = {`REPLY_ACK, s_q.field0, s_q.vol[slot*8 +: 8]};
                        s_d.reply_len = 2'd3;
                    end else if (reg_kind(s_q.field0) == 2'd2) begin
                        s_d.reply = {`REPLY_ACK, s_q.field0, s_q.nv[slot*8 +: 8]};
                        s_d.reply_len = 2'd3;
                    end else if (reg_kind(s_q.field0) == 2'd3) begin
                        s_d.reply = {`REPLY_ACK, s_q.field0, 8'h00};
                        s_d.reply_len = 2'd3;
                    end // Else NAK, see R17
                end else if (!s_q.rd && s_q.nfields == 2'd2
                             && (s_q.size == `SIZE_LONG) == s_q.field1[7]) begin // see R9 R10
                    if (reg_kind(s_q.field0) == 2'd1) begin
                        s_d.vol[slot*8 +: 8] = s_q.field1; // see R11
                        s_d.reply = {`REPLY_ACK, 16'h0000}; // see R12
                    end else if (reg_kind(s_q.field0) == 2'd2) begin
                        s_d.nv[slot*8 +: 8] = s_q.field1;
                        s_d.reply = {`REPLY_ACK, 16'h0000};
                        s_d.wait_cnt = 24'(NV_WRITE_CYCLES);
                        s_d.st = cmd_link_pkg::P_NVWAIT; // see R11
                    end // Else NAK, nothing stored, see R14
                end else begin
                    s_d.st = cmd_link_pkg::P_DROP; // see R18
                end
            end
            cmd_link_pkg::P_NVWAIT: begin
                // Stall: parser takes no bytes until the mirror write ends
                s_d.wait_cnt = s_q.wait_cnt - 24'd1;
                if (s_q.wait_cnt <= 24'd1) s_d.st = cmd_link_pkg::P_REPLY; // see R11
            end
            cmd_link_pkg::P_REPLY: begin
                s_d.tx_data = s_q.reply[23:16];
                s_d.tx_valid = 1'b1;
                s_d.reply = {s_q.reply[15:0], 8'h00};
                s_d.reply_len = s_q.reply_len - 2'd1;
                if (s_q.reply_len == 2'd1) s_d.st = cmd_link_pkg::P_IDLE; // see R18
            end
            default: s_d.st = cmd_link_pkg::P_IDLE;
        endcase
        // Judged on next state: no radio byte meets a reply
        s_d.radio_ready = (s_d.st != cmd_link_pkg::P_REPLY); // see R5
    end

    // ****
    // State register
    // ****
    // Mirrors model flash: reset clears them; a real part keeps them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= cmd_link_pkg::P_LOAD;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // cmd_device

// ---- cmd_host.sv ----
`timescale 1ns/10ps
`include "cmd_link_defines.svh"
// Host end: frames one read or write, holds select low, passes replies out on resp
module cmd_host (
    input wire logic ref_clk,
    input wire logic reset,
    cmd_link_if.host link,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_reg,
    input wire logic [7:0] req_value,
    output logic req_ready,
    output logic [7:0] resp_data,
    output logic resp_valid
);
    typedef struct packed {
        cmd_link_pkg::host_state_t st;
        logic [39:0] frame;
        logic [2:0] left;
        logic [7:0] hold;
        logic [7:0] data;
        logic valid;
        logic sel_n;
        logic [7:0] resp;
        logic resp_v;
    } host_s_t;

    host_s_t h_q;
    host_s_t h_d;

    assign link.rx_data = h_q.data;
    assign link.rx_valid = h_q.valid;
    assign link.command_select_n = h_q.sel_n;
    assign req_ready = (h_q.st == cmd_link_pkg::H_IDLE);
    assign resp_data = h_q.resp;
    assign resp_valid = h_q.resp_v;

    // Build the escaped frame; read uses the escape as marker
    always_comb begin
        h_d = h_q;
        h_d.resp_v = link.tx_valid;
        h_d.resp = link.tx_data;
        case (h_q.st)
            cmd_link_pkg::H_IDLE: begin
                h_d.sel_n = 1'b1;
                if (req_valid) begin
                    h_d.sel_n = 1'b0;
                    h_d.st = cmd_link_pkg::H_SEND;
                    if (!req_write) begin
                        h_d.frame = {`FRAME_HEADER, `SIZE_SHORT, `FRAME_ESCAPE, req_reg, 8'h00};
                        h_d.left = 3'd4; // see R15
                    end else if (req_value[7]) begin
                        h_d.frame = {`FRAME_HEADER, `SIZE_LONG, req_reg, `FRAME_ESCAPE,
                                     req_value & 8'h7F};
                        h_d.left = 3'd5; // see R10 R7
                    end else begin
                        h_d.frame = {`FRAME_HEADER, `SIZE_SHORT, req_reg, req_value, 8'h00};
                        h_d.left = 3'd4; // see R9 R8
                    end
                end
            end
            cmd_link_pkg::H_SEND: begin
                if (!h_q.valid || link.rx_ready) begin
                    h_d.valid = (h_q.left != 3'd0);
                    h_d.data = h_q.frame[39:32];
                    h_d.frame = {h_q.frame[31:0], 8'h00};
                    if (h_q.left != 3'd0) h_d.left = h_q.left - 3'd1;
                    else begin
                        h_d.hold = 8'(`SELECT_HOLD_CYC);
                        h_d.st = cmd_link_pkg::H_HOLD;
                    end
                end
            end
            cmd_link_pkg::H_HOLD: begin
                // Keep select low past the last byte
                h_d.hold = h_q.hold - 8'd1;
                if (h_q.hold == 8'd0) h_d.st = cmd_link_pkg::H_WAIT; // see R3
            end
            cmd_link_pkg::H_WAIT: begin
                // Replies go out through resp; retry is the user's job
                h_d.sel_n = 1'b1;
                h_d.st = cmd_link_pkg::H_IDLE; // see R13
            end
            default: h_d.st = cmd_link_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            h_q <= '0;
            h_q.st <= cmd_link_pkg::H_IDLE;
            h_q.sel_n <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end
endmodule // cmd_host

// ---- cmd_link_monitor.sv ----
`timescale 1ns/10ps
// ****
// Checker on the host-device link
// ****
module cmd_link_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic command_select_n
);
    default clocking mcb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    logic take, fend, read_q, body1_q, esc_q, first_q;
    logic [1:0] pos_q;
    logic [7:0] left_q, rd_reg_q, quiet_q;
    assign take = rx_valid && rx_ready;
    assign fend = take && pos_q == 2'd2 && left_q == 8'h01;
    // Frame tracker; the gap count saturates so long idles stay legal
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {pos_q, read_q, body1_q, esc_q, first_q, left_q, rd_reg_q} <= '0;
            quiet_q <= 8'hFF;
        end else begin
            quiet_q <= take ? 8'h00 : quiet_q + {7'h00, quiet_q != 8'hFF};
            if (tx_valid) first_q <= 1'b0;
            if (take) begin
                esc_q <= pos_q == 2'd2 && rx_data == 8'hFE;
                body1_q <= pos_q == 2'd1;
                if (pos_q == 2'd1) begin
                    pos_q <= 2'd2;
                    left_q <= rx_data;
                end else if (pos_q == 2'd2) begin
                    left_q <= left_q - 8'h01;
                    read_q <= read_q || (body1_q && rx_data == 8'hFE);
                end else if (rx_data == 8'hFF) begin
                    pos_q <= 2'd1;
                    read_q <= 1'b0;
                end
                if (fend) begin
                    pos_q <= 2'd0;
                    first_q <= 1'b1;
                    rd_reg_q <= rx_data;
                end
            end
        end
    end
    // First reply byte of a frame, then the rest of a read answer
    sequence s_ack_first;
        tx_valid && first_q && tx_data == 8'h06;
    endsequence
    sequence s_read_tail;
        tx_valid && tx_data == rd_reg_q ##1 tx_valid;
    endsequence
    AST_SIZE_BYTE: assert property (
        take && pos_q == 2'd1 |-> rx_data inside {8'h02, 8'h03}) else $error("bad size byte");
    AST_BODY_ENCODED: assert property (
        take && pos_q == 2'd2 |-> !rx_data[7] || rx_data == 8'hFE) else $error("raw high byte");
    AST_ESC_LOW7: assert property (
        take && esc_q |-> !rx_data[7]) else $error("escaped byte too big");
    AST_SELECT_IN_FRAME: assert property (
        take && (pos_q != 2'd0 || rx_data == 8'hFF) |-> !command_select_n)
        else $error("frame byte with select high");
    AST_SELECT_MARGIN: assert property (
        $rose(command_select_n) |-> quiet_q >= 8'hC7) else $error("select released early");
    AST_REPLY_DUE: assert property (
        fend |-> ##[1:40] tx_valid && tx_data inside {8'h06, 8'h15}) else $error("no reply");
    AST_WRITE_ACK_ALONE: assert property (
        s_ack_first ##0 !read_q |=> !tx_valid) else $error("write ack not single");
    AST_READ_REPLY: assert property (
        s_ack_first ##0 read_q |=> s_read_tail) else $error("bad read answer");
    AST_NAK_ALONE: assert property (
        tx_valid && first_q && tx_data == 8'h15 |=> !tx_valid) else $error("nak not single");
endmodule // cmd_link_monitor

// ---- uart_register_command_parser_tb.sv ----
`timescale 1ns/10ps
`include "cmd_link_defines.svh"
// ****
// Host and device face to face, plus a far device driven by the bench
// ****
module uart_register_command_parser_tb;
    logic ref_clk, reset, req_valid, req_write, req_ready, resp_valid, pv1;
    logic pay_valid, pay_ready, radio_valid, radio_ready;
    logic [7:0] req_reg, req_value, resp_data, pay_data, radio_data;
    logic [`REG_COUNT*8-1:0] cfg, cfg2;
    logic [7:0] vol [14], nv [14];
    logic [7:0] q_resp [$], q_tx [$], q_pay [$];
    int num_errors, total_checks;
    cmd_link_if link();
    cmd_link_if link2();
    cmd_host cmd_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link.host),
        .req_valid(req_valid), .req_write(req_write), .req_reg(req_reg),
        .req_value(req_value), .req_ready(req_ready), .resp_data(resp_data),
        .resp_valid(resp_valid));
    // Short mirror write time keeps the run brief
    cmd_device #(.NV_WRITE_CYCLES(20)) cmd_device_inst (.ref_clk(ref_clk), .reset(reset),
        .link(link.device), .payload_data(), .payload_valid(pv1), .payload_ready(pay_ready),
        .radio_data(radio_data), .radio_valid(radio_valid), .radio_ready(), .config_regs(cfg));
    if (1) begin : far_end
        cmd_device #(.NV_WRITE_CYCLES(20)) cmd_device_inst (.ref_clk(ref_clk),
            .reset(reset), .link(link2.device), .payload_data(pay_data),
            .payload_valid(pay_valid), .payload_ready(pay_ready), .radio_data(radio_data),
            .radio_valid(radio_valid), .radio_ready(radio_ready), .config_regs(cfg2));
    end
    cmd_link_monitor cmd_link_monitor_inst (.ref_clk(ref_clk), .reset(reset),
        .rx_data(link.rx_data), .rx_valid(link.rx_valid), .rx_ready(link.rx_ready),
        .tx_data(link.tx_data), .tx_valid(link.tx_valid),
        .command_select_n(link.command_select_n));
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        num_errors++;
        $display("unexpected %s: expected done seen timeout", what);
        complete_run();
    endtask
    task automatic take(ref logic [7:0] q[$], input string what, input logic [7:0] got);
        if (q.size() == 0) begin
            num_errors++;
            $display("unexpected %s: expected none seen %h", what, got);
        end else begin
            chk(what, q.pop_front(), got);
        end
    endtask
    // Watcher: each output byte meets the oldest note
    always @(posedge ref_clk) begin
        if (reset === 1'b0) begin
            if (resp_valid === 1'b1) take(q_resp, "reply", resp_data);
            if (link2.tx_valid === 1'b1) take(q_tx, "far reply", link2.tx_data);
            if ((pay_valid & pay_ready) === 1'b1) take(q_pay, "payload", pay_data);
            if (pv1 !== 1'b0) chk("command payload", 8'h00, 8'h01);
        end
    end
    // Host request; expected answer from the register model
    task automatic op(input logic wr, input logic [7:0] r, input logic [7:0] v);
        int n;
        bit vh, nh, rh;
        vh = r >= `VOL_BASE && r <= `VOL_LAST;
        nh = r <= `NV_LAST;
        rh = r >= `RO_BASE && r <= `RO_LAST;
        if (wr && (vh || nh)) begin
            q_resp.push_back(8'h06);
            if (vh) vol[r - `VOL_BASE] = v;
            else nv[r] = v;
        end else if (wr || !(vh || nh || rh)) begin
            q_resp.push_back(8'h15);
        end else begin
            q_resp.push_back(8'h06);
            q_resp.push_back(r);
            q_resp.push_back(vh ? vol[r - `VOL_BASE] : nh ? nv[r] : 8'h00);
        end
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_reg = r;
        req_value = v;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 500);
        if (req_ready !== 1'b1) hang("host request");
        @(negedge ref_clk);
        req_valid = 1'b0;
        repeat (3) @(posedge ref_clk);
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 2000) hang("host done");
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < `REG_COUNT; i++) chk("register", vol[i], cfg[i*8 +: 8]);
    endtask
    // Far end byte; a refused one stays held on return
    task automatic send2(input logic [7:0] b, input int lim, output bit ok);
        int n;
        @(negedge ref_clk);
        link2.rx_valid = 1'b1;
        link2.rx_data = b;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (link2.rx_ready !== 1'b1 && n < lim);
        ok = link2.rx_ready === 1'b1;
        if (!ok && lim > 9) hang("far byte");
    endtask
    // Release shows inverse data so no stale byte looks fresh
    task automatic idle2;
        @(negedge ref_clk);
        link2.rx_valid = 1'b0;
        link2.rx_data = ~link2.rx_data;
    endtask
    task automatic burst2(input logic [63:0] s, input int n);
        bit ok;
        for (int i = n - 1; i >= 0; i--) send2(s[i*8 +: 8], 50, ok);
        idle2();
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (q_resp.size() + q_tx.size() + q_pay.size() != 0 && n < 300) begin
            @(negedge ref_clk);
            pay_ready = 1'($urandom);
            n++;
        end
        pay_ready = 1'b1;
        if (n >= 300) hang("outputs");
    endtask
    // Main sequence
    initial begin
        int acc;
        bit ok;
        logic [7:0] b;
        void'($urandom(81141));
        {reset, req_valid, req_write, req_reg, req_value} = {2'b10, 17'h0_0000};
        {pay_ready, radio_valid, radio_data} = 10'h000;
        {link2.rx_valid, link2.rx_data, link2.command_select_n} = 10'h001;
        {num_errors, total_checks} = 0;
        for (int i = 0; i < 14; i++) {vol[i], nv[i]} = 16'h0000;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        repeat (20) @(negedge ref_clk);
        $display("test load done");
        op(1, `VOL_BASE, 8'h7F);
        op(1, `VOL_LAST, 8'h80);
        for (int i = 0; i < 4; i++) op(1, `VOL_BASE + 8'($urandom_range(0, 13)), 8'($urandom));
        op(0, `VOL_LAST, 8'h00);
        op(0, `VOL_BASE, 8'h00);
        $display("test volatile done");
        op(1, 8'h05, 8'($urandom) | 8'h80);
        op(0, 8'h05, 8'h00);
        op(1, `RO_BASE, 8'h12);
        op(1, 8'h30, 8'h34);
        op(0, 8'h30, 8'h00);
        op(0, `RO_LAST, 8'h00);
        $display("test mirror and refusal done");
        // Far end: junk and bad size skipped to next header
        @(negedge ref_clk);
        link2.command_select_n = 1'b0;
        q_tx.push_back(8'h06);
        burst2(64'h4B33_FF07_FF02_4B11, 8);
        drain();
        chk("far register", 8'h11, cfg2[7:0]);
        q_tx.push_back(8'h06);
        burst2(64'h0000_00FF_034C_FE05, 5);
        drain();
        chk("far register", 8'h85, cfg2[15:8]);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            q_tx.push_back(b);
            q_resp.push_back(b);
            @(negedge ref_clk);
            {radio_valid, radio_data} = {1'b1, b};
            acc = 0;
            do begin
                @(posedge ref_clk);
                acc++;
            end while (radio_ready !== 1'b1 && acc < 50);
            if (radio_ready !== 1'b1) hang("radio byte");
            @(negedge ref_clk);
            {radio_valid, radio_data} = {1'b0, ~b};
        end
        drain();
        repeat (300) @(negedge ref_clk);
        q_tx = {q_tx, 8'h06, 8'h4C, 8'h85};
        burst2(64'h0000_0000_FF02_FE4C, 4);
        drain();
        repeat (`SELECT_HOLD_CYC) @(negedge ref_clk);
        link2.command_select_n = 1'b1;
        $display("test far commands done");
        // Payload mode, stalled sink: fill until refused
        pay_ready = 1'b0;
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 20) begin
            b = acc == 0 ? 8'hFF : 8'($urandom);
            send2(b, 4, ok);
            if (ok) q_pay.push_back(b);
            if (ok) acc++;
        end
        idle2();
        chk("buffer refused", 8'h01, {7'h00, acc >= `FIFO_DEPTH && acc < 20});
        drain();
        chk("payload left", 8'h00, {7'h00, pay_valid});
        $display("test payload done");
        chk("outstanding", 8'h00, 8'(q_resp.size() + q_tx.size() + q_pay.size()));
        complete_run();
    end
endmodule // uart_register_command_parser_tb
